// ===== src/codec_port_pkg.sv
// shared constants and types for the strobed pcm codec port
package codec_port_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register byte offsets on the ahb-lite bus
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] TXDATA_OFS = 8'h08;
    localparam logic [7:0] RXDATA_OFS = 8'h0c;
    localparam logic [7:0] FRAMES_OFS = 8'h10;
    localparam logic [7:0] TICKS_OFS = 8'h14;

    // field positions
    localparam int CTRL_EN_POS = 0;
    localparam int RXD_VALID_POS = 8;
    localparam int RXD_OVERRUN_POS = 9;
    localparam int ST_LAW_POS = 0;
    localparam int ST_RXQ_POS = 1;
    localparam int ST_TXQ_POS = 2;
    localparam int ST_SPEED_POS = 4;
    localparam int ST_TXAV_POS = 8;
    localparam int ST_TXRDY_POS = 9;
    localparam int ST_RXV_POS = 10;
    localparam int ST_POR_POS = 11;

    // reset values
    localparam logic CTRL_EN_RESET = 1'b0;
    localparam logic [15:0] COUNT_RESET = 16'h0000;

    ////////////////////////////////////////////////////////////////////////
    // companded code points
    localparam logic [7:0] QUIET_MU = 8'h7f;
    localparam logic [7:0] QUIET_A = 8'h55;
    localparam logic [7:0] POS_ZERO_MU = 8'hff;
    localparam logic [7:0] POS_ZERO_A = 8'hd5;
    localparam int BYTE_BITS = 8;

    // speed select codes, bit 2 down to bit 0
    localparam logic [2:0] SPD_512 = 3'h0;
    localparam logic [2:0] SPD_1536 = 3'h1;
    localparam logic [2:0] SPD_2048 = 3'h2;
    localparam logic [2:0] SPD_4096 = 3'h3;
    localparam logic [2:0] SPD_128 = 3'h4;
    localparam logic [2:0] SPD_256 = 3'h5;

    // core clock to 512 khz converter clock division
    localparam logic [3:0] DIV_1 = 4'h1;
    localparam logic [3:0] DIV_3 = 4'h3;
    localparam logic [3:0] DIV_4 = 4'h4;
    localparam logic [3:0] DIV_8 = 4'h8;

    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic por_n;
        logic law_a;
        logic rx_quiet;
        logic tx_quiet;
        logic [2:0] speed;
        logic core_clk;
        logic bclk;
        logic strobe;
        logic din;
    } pins_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] addr;
    } dphase_t;

    typedef enum logic [0:0] {SLOT_IDLE, SLOT_BUSY} slot_state_t;

endpackage

// ===== src/pin_sync.sv
// three-stage synchroniser with agreement filter, one per bit
`timescale 1ns/100ps
module pin_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [W-1:0] pin_i,
    output logic [W-1:0] level_o
);
    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_bit
            logic s1_reg;
            logic s2_reg;
            logic s3_reg;
            logic lvl_reg;
            always_ff @(posedge clk_i)
            begin
                if (!nrst_i)
                begin
                    s1_reg <= 1'b0;
                    s2_reg <= 1'b0;
                    s3_reg <= 1'b0;
                    lvl_reg <= 1'b0;
                end
                else
                begin
                    s1_reg <= pin_i[i];
                    s2_reg <= s1_reg;
                    s3_reg <= s2_reg;
                    // a change counts only once stages two and three agree
                    if (s2_reg == s3_reg)
                        lvl_reg <= s3_reg;
                end
            end
            assign level_o[i] = lvl_reg;
        end
    endgenerate
endmodule // pin_sync

// ===== src/pair_buffer.sv
// two-entry valid/ready buffer with registered output
`timescale 1ns/100ps
module pair_buffer #(
    parameter int W = 8
) (
    input wire logic clk_i,
    input wire logic clr_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [W-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o
);
    logic [W-1:0] head_reg;
    logic [W-1:0] tail_reg;
    logic [1:0] cnt_reg;
    logic push;
    logic pop;

    assign in_ready_o = (cnt_reg != 2'h2);
    assign out_valid_o = (cnt_reg != 2'h0);
    assign out_data_o = head_reg;
    assign push = in_valid_i && in_ready_o;
    assign pop = out_ready_i && out_valid_o;

    always_ff @(posedge clk_i)
    begin
        if (clr_i)
        begin
            cnt_reg <= 2'h0;
            head_reg <= '0;
            tail_reg <= '0;
        end
        else
        begin
            cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
            if (push && (cnt_reg == 2'h0 || (cnt_reg == 2'h1 && pop)))
                head_reg <= in_data_i;
            else if (pop)
                head_reg <= tail_reg;
            if (push && cnt_reg != 2'h0)
                tail_reg <= in_data_i;
        end
    end
endmodule // pair_buffer

// ===== src/codec_port.sv
// digital side of a single-channel pcm codec: strobed serial port
//
// Our own choices: the register addresses and the AHB-Lite register port.
`timescale 1ns/100ps
module codec_port (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    // ahb-lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic [31:0] hrdata_o,
    // device pins
    input wire logic power_up_reset_n_i,
    input wire logic law_sel_a_i,
    input wire logic receive_quiet_force_i,
    input wire logic transmit_quiet_force_i,
    input wire logic clock_speed_sel_bit0_i,
    input wire logic clock_speed_sel_bit1_i,
    input wire logic clock_speed_sel_bit2_i,
    input wire logic core_clock_in_i,
    input wire logic serial_bit_clock_i,
    input wire logic slot_strobe_i,
    input wire logic serial_data_i,
    output logic serial_data_o,
    output logic serial_data_oe_o
);

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    codec_port_pkg::pins_t raw;
    codec_port_pkg::pins_t lp;

    assign raw.por_n = power_up_reset_n_i;
    assign raw.law_a = law_sel_a_i;
    assign raw.rx_quiet = receive_quiet_force_i;
    assign raw.tx_quiet = transmit_quiet_force_i;
    assign raw.speed = {clock_speed_sel_bit2_i, clock_speed_sel_bit1_i,
        clock_speed_sel_bit0_i};
    assign raw.core_clk = core_clock_in_i;
    assign raw.bclk = serial_bit_clock_i;
    assign raw.strobe = slot_strobe_i;
    assign raw.din = serial_data_i;

    pin_sync #(
        .W($bits(codec_port_pkg::pins_t))
    ) u_sync (
        .clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .pin_i(raw),
        .level_o(lp)
    );

    ////////////////////////////////////////////////////////////////////////
    // state declarations
    logic clr;
    logic en_reg;
    logic bclk_prev_reg;
    logic strb_prev_reg;
    logic core_prev_reg;
    codec_port_pkg::slot_state_t slot_reg;
    codec_port_pkg::slot_state_t slot_next;
    logic [7:0] tx_shift_reg;
    logic [7:0] tx_hold_reg;
    logic [3:0] tx_cnt_reg;
    logic [7:0] rx_shift_reg;
    logic [7:0] rx_hold_reg;
    logic [3:0] rx_cnt_reg;
    logic [7:0] rx_data_reg;
    logic rx_valid_reg;
    logic rx_overrun_reg;
    logic dout_reg;
    logic oe_reg;
    logic [15:0] frames_reg;
    logic [15:0] ticks_reg;
    logic [3:0] div_cnt_reg;
    codec_port_pkg::dphase_t dp_reg;
    logic hready_reg;
    logic [31:0] hrdata_reg;

    ////////////////////////////////////////////////////////////////////////
    // edges, law and mode decode
    logic bclk_rise;
    logic bclk_fall;
    logic strb_rise;
    logic core_rise;
    logic slow_mode;
    logic [7:0] quiet_code;
    logic [3:0] div_ratio;

    // either reset clears all but the pin synchronisers, which only nrst_i clears; the pin only after its filter agrees
    assign clr = !nrst_i || !lp.por_n;
    assign bclk_rise = lp.bclk && !bclk_prev_reg;
    assign bclk_fall = !lp.bclk && bclk_prev_reg;
    assign strb_rise = lp.strobe && !strb_prev_reg && en_reg;
    assign core_rise = lp.core_clk && !core_prev_reg;
    // 128 and 256 khz codes run from the 4096 khz master clock
    assign slow_mode = (lp.speed == codec_port_pkg::SPD_128)
        || (lp.speed == codec_port_pkg::SPD_256);
    // negative zero of the selected law, already in inverted-digit form
    assign quiet_code = lp.law_a ? codec_port_pkg::QUIET_A
        : codec_port_pkg::QUIET_MU;
    assign div_ratio = (lp.speed == codec_port_pkg::SPD_512) ? codec_port_pkg::DIV_1
        : (lp.speed == codec_port_pkg::SPD_1536) ? codec_port_pkg::DIV_3
        : (lp.speed == codec_port_pkg::SPD_2048) ? codec_port_pkg::DIV_4
        : codec_port_pkg::DIV_8;

    ////////////////////////////////////////////////////////////////////////
    // transmit buffer
    logic tx_push;
    logic tx_in_ready;
    logic tx_avail;
    logic [7:0] tx_head;

    pair_buffer #(
        .W(codec_port_pkg::BYTE_BITS)
    ) u_txbuf (
        .clk_i(sys_clk_i),
        .clr_i(clr),
        .in_valid_i(tx_push),
        .in_ready_o(tx_in_ready),
        .in_data_i(hwdata_i[7:0]),
        .out_valid_o(tx_avail),
        .out_ready_i(strb_rise),
        .out_data_o(tx_head)
    );

    ////////////////////////////////////////////////////////////////////////
    // serial byte selection
    logic [7:0] tx_fresh;
    logic [7:0] tx_send;
    logic [7:0] tx_cur;
    logic tx_step;
    logic rx_step;
    logic [3:0] rx_base;
    logic [7:0] rx_byte;
    logic rx_done;
    logic [7:0] rx_fresh;
    logic [7:0] rx_deliver;

    // an empty buffer sends quiet code rather than stale data
    assign tx_fresh = tx_avail ? tx_head : quiet_code;
    assign tx_send = lp.tx_quiet ? quiet_code
        : (slow_mode ? tx_hold_reg : tx_fresh);
    assign tx_cur = strb_rise ? tx_send : tx_shift_reg;
    assign tx_step = lp.strobe && en_reg && bclk_rise
        && (strb_rise || slot_reg == codec_port_pkg::SLOT_BUSY)
        && (strb_rise || tx_cnt_reg < 4'(codec_port_pkg::BYTE_BITS));
    assign rx_base = strb_rise ? 4'h0 : rx_cnt_reg;
    assign rx_step = lp.strobe && en_reg && bclk_fall
        && (strb_rise || slot_reg == codec_port_pkg::SLOT_BUSY)
        && rx_base < 4'(codec_port_pkg::BYTE_BITS);
    assign rx_byte = {rx_shift_reg[6:0], lp.din};
    assign rx_done = rx_step
        && rx_base == 4'(codec_port_pkg::BYTE_BITS - 1);
    assign rx_fresh = lp.rx_quiet ? quiet_code : rx_byte;
    assign rx_deliver = slow_mode ? rx_hold_reg : rx_fresh;

    ////////////////////////////////////////////////////////////////////////
    // slot state machine
    always_comb
    begin
        slot_next = slot_reg;
        case (slot_reg)
            codec_port_pkg::SLOT_IDLE:
                if (strb_rise)
                    slot_next = codec_port_pkg::SLOT_BUSY;
            codec_port_pkg::SLOT_BUSY:
                if (!lp.strobe || !en_reg)
                    slot_next = codec_port_pkg::SLOT_IDLE;
            default:
                slot_next = codec_port_pkg::SLOT_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (clr)
        begin
            slot_reg <= codec_port_pkg::SLOT_IDLE;
            bclk_prev_reg <= 1'b0;
            strb_prev_reg <= 1'b0;
            core_prev_reg <= 1'b0;
        end
        else
        begin
            slot_reg <= slot_next;
            bclk_prev_reg <= lp.bclk;
            strb_prev_reg <= lp.strobe;
            core_prev_reg <= lp.core_clk;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // transmit shifter, msb first
    always_ff @(posedge sys_clk_i)
    begin
        if (clr)
        begin
            tx_shift_reg <= 8'h00;
            tx_cnt_reg <= 4'h0;
            tx_hold_reg <= codec_port_pkg::QUIET_MU;
            dout_reg <= 1'b0;
        end
        else
        begin
            if (strb_rise)
                tx_hold_reg <= tx_fresh;
            if (tx_step)
            begin
                dout_reg <= tx_cur[7];
                tx_shift_reg <= {tx_cur[6:0], 1'b0};
                tx_cnt_reg <= (strb_rise ? 4'h0 : tx_cnt_reg) + 4'h1;
            end
            else if (strb_rise)
            begin
                tx_shift_reg <= tx_send;
                tx_cnt_reg <= 4'h0;
            end
            if (!lp.strobe)
                dout_reg <= 1'b0;
        end
    end

    // output driven only while the strobe marks the slot
    always_ff @(posedge sys_clk_i)
    begin
        if (clr)
            oe_reg <= 1'b0;
        else
            oe_reg <= lp.strobe && en_reg;
    end

    ////////////////////////////////////////////////////////////////////////
    // receive shifter
    always_ff @(posedge sys_clk_i)
    begin
        if (clr)
        begin
            rx_shift_reg <= 8'h00;
            rx_cnt_reg <= 4'h0;
            rx_hold_reg <= codec_port_pkg::QUIET_MU;
        end
        else
        begin
            if (rx_step)
            begin
                rx_shift_reg <= rx_byte;
                rx_cnt_reg <= rx_base + 4'h1;
            end
            else if (strb_rise)
                rx_cnt_reg <= 4'h0;
            if (rx_done)
                rx_hold_reg <= rx_fresh;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // ahb-lite decode
    logic take;
    logic take_rd_rx;
    logic dp_is_tx;
    logic [31:0] status_word;
    logic [31:0] rd_mux;

    assign take = hsel_i && hready_i && htrans_i[1];
    assign take_rd_rx = take && !hwrite_i && haddr_i[7:0] == codec_port_pkg::RXDATA_OFS;
    assign dp_is_tx = dp_reg.valid && dp_reg.write
        && dp_reg.addr == codec_port_pkg::TXDATA_OFS;
    // a word enters the buffer only from a wait state, so a full buffer stalls
    assign tx_push = dp_is_tx && !hready_reg && tx_in_ready;
    assign status_word = {20'h00000, lp.por_n, rx_valid_reg, tx_in_ready, tx_avail,
        1'b0, lp.speed, 1'b0, lp.tx_quiet, lp.rx_quiet, lp.law_a};
    assign rd_mux = (haddr_i[7:0] == codec_port_pkg::CTRL_OFS) ? {31'h0, en_reg}
        : (haddr_i[7:0] == codec_port_pkg::STATUS_OFS) ? status_word
        : (haddr_i[7:0] == codec_port_pkg::RXDATA_OFS)
            ? {22'h0, rx_overrun_reg, rx_valid_reg, rx_data_reg}
        : (haddr_i[7:0] == codec_port_pkg::FRAMES_OFS) ? {16'h0, frames_reg}
        : (haddr_i[7:0] == codec_port_pkg::TICKS_OFS) ? {16'h0, ticks_reg}
        : 32'h0000_0000;

    always_ff @(posedge sys_clk_i)
    begin
        if (clr)
        begin
            dp_reg <= '0;
            hready_reg <= 1'b1;
            hrdata_reg <= 32'h0000_0000;
        end
        else
        begin
            if (hready_reg)
            begin
                dp_reg.valid <= take;
                dp_reg.write <= hwrite_i;
                dp_reg.addr <= {haddr_i[7:2], 2'b00};
                hready_reg <= !(take && hwrite_i
                    && haddr_i[7:0] == codec_port_pkg::TXDATA_OFS);
                hrdata_reg <= (take && !hwrite_i) ? rd_mux : 32'h0000_0000;
            end
            else if (tx_push)
                hready_reg <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control and receive data registers
    logic ctrl_wr;

    assign ctrl_wr = dp_reg.valid && dp_reg.write && hready_reg
        && dp_reg.addr == codec_port_pkg::CTRL_OFS;

    always_ff @(posedge sys_clk_i)
    begin
        if (clr)
            en_reg <= codec_port_pkg::CTRL_EN_RESET;
        else if (ctrl_wr)
            en_reg <= hwdata_i[codec_port_pkg::CTRL_EN_POS];
    end

    // a new byte in the same cycle as the read wins over the clear
    always_ff @(posedge sys_clk_i)
    begin
        if (clr)
        begin
            rx_data_reg <= codec_port_pkg::QUIET_MU;
            rx_valid_reg <= 1'b0;
            rx_overrun_reg <= 1'b0;
        end
        else if (rx_done)
        begin
            rx_data_reg <= rx_deliver;
            rx_valid_reg <= 1'b1;
            rx_overrun_reg <= !take_rd_rx && (rx_overrun_reg || rx_valid_reg);
        end
        else if (take_rd_rx)
        begin
            rx_valid_reg <= 1'b0;
            rx_overrun_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // frame counter and converter clock divider
    always_ff @(posedge sys_clk_i)
    begin
        if (clr)
        begin
            frames_reg <= codec_port_pkg::COUNT_RESET;
            ticks_reg <= codec_port_pkg::COUNT_RESET;
            div_cnt_reg <= 4'h0;
        end
        else
        begin
            if (strb_rise)
                frames_reg <= frames_reg + 16'h0001;
            if (core_rise)
            begin
                // one converter tick per div_ratio core clock edges
                if (div_cnt_reg + 4'h1 >= div_ratio)
                begin
                    div_cnt_reg <= 4'h0;
                    ticks_reg <= ticks_reg + 16'h0001;
                end
                else
                    div_cnt_reg <= div_cnt_reg + 4'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign hreadyout_o = hready_reg;
    assign hresp_o = 1'b0;
    assign hrdata_o = hrdata_reg;
    assign serial_data_o = dout_reg;
    assign serial_data_oe_o = oe_reg;

endmodule // codec_port

// ===== bench/codec_port_props.sv
// concurrent checks on the codec port pins and bus answer
`timescale 1ns/100ps
module codec_port_props (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic hready_i,
    input wire logic hreadyout_o,
    input wire logic hresp_o,
    input wire logic [31:0] hrdata_o,
    input wire logic power_up_reset_n_i,
    input wire logic slot_strobe_i,
    input wire logic serial_data_o,
    input wire logic serial_data_oe_o
);
    default clocking dc @(posedge sys_clk_i);
    endclocking
    default disable iff (!nrst_i);
    logic take;
    logic tx_take;
    assign take = hsel_i && hready_i && htrans_i[1];
    assign tx_take = take && hwrite_i && haddr_i[7:0] == codec_port_pkg::TXDATA_OFS;
    ////////////////////////////////////////////////////////////////////////
    bus_okay_a: assert property (hresp_o == 1'b0)
        else $error("bus response not okay");
    reset_clear_a: assert property (disable iff (1'b0) !nrst_i |=>
        hreadyout_o && !serial_data_oe_o && hrdata_o == 32'h0)
        else $error("outputs not cleared by reset");
    por_clear_a: assert property (!power_up_reset_n_i [*8] |->
        !serial_data_oe_o && hreadyout_o && hrdata_o == 32'h0)
        else $error("power-up pin did not clear the port");
    idle_tristate_a: assert property (!slot_strobe_i [*8] |-> !serial_data_oe_o)
        else $error("serial output driven outside the slot");
    quiet_line_a: assert property (!serial_data_oe_o |-> !serial_data_o)
        else $error("serial data not parked low while undriven");
    oe_in_slot_a: assert property ($rose(serial_data_oe_o)
        |-> $past(slot_strobe_i, 3))
        else $error("output enabled without a strobe");
    read_nowait_a: assert property (take && !hwrite_i |=> hreadyout_o)
        else $error("read took a wait state");
    write_nowait_a: assert property (take && hwrite_i && !tx_take |=> hreadyout_o)
        else $error("register write took a wait state");
    tx_wait_a: assert property (tx_take |=> !hreadyout_o)
        else $error("transmit byte write did not wait");
endmodule // codec_port_props

bind codec_port codec_port_props codec_port_props_inst (.sys_clk_i, .nrst_i, .hsel_i,
    .haddr_i, .htrans_i, .hwrite_i, .hready_i, .hreadyout_o, .hresp_o, .hrdata_o,
    .power_up_reset_n_i, .slot_strobe_i, .serial_data_o, .serial_data_oe_o);

// ===== bench/ssi_far_end.sv
// far-end layer-1 model: strobe, bit clock, master clock and serial data
`timescale 1ns/100ps
module ssi_far_end #(
    parameter int FRAME_NS = 125000
) (
    input wire logic slow_i,
    input wire logic dout_i,
    input wire logic oe_i,
    output logic bclk_o,
    output logic strobe_o,
    output logic din_o,
    output logic core_clk_o
);
    logic mclk = 1'b0;
    initial
    begin
        bclk_o = 1'b0;
        strobe_o = 1'b0;
        din_o = 1'b0;
    end
    always #122 mclk = ~mclk;
    // slow bit clocks need the free-running 4096 khz master clock
    assign core_clk_o = slow_i ? mclk : bclk_o;
    ////////////////////////////////////////////////////////////////////////
    // one strobed slot; the bit clock stands still between slots
    task automatic frame(input logic [7:0] tx, output logic [7:0] rx);
        #3; // stay clear of the system clock edge
        strobe_o = 1'b1;
        for (int i = 7; i >= 0; i--)
        begin
            bclk_o = 1'b1;
            din_o = tx[i];
            #80 bclk_o = 1'b0;
            // read late in the bit: the answer trails the rise by a few clocks
            #75 rx[i] = oe_i ? dout_i : !dout_i;
            #5;
        end
        strobe_o = 1'b0;
        din_o = ~din_o;
        #(FRAME_NS - 1280);
    endtask
endmodule // ssi_far_end

// ===== bench/tb_codec_port.sv
// self-checking bench for the codec port: bus tasks and serial frames
`timescale 1ns/100ps
module tb_codec_port;
    logic sys_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic pur_n = 1'b1;
    logic law = 1'b0;
    logic rxq = 1'b0;
    logic txq = 1'b0;
    logic slow = 1'b0;
    logic [2:0] spd = 3'h3;
    logic bclk, strobe, din, core_clk, dout, oe;
    logic [31:0] v, t0;
    logic [7:0] got, q;
    logic [2:0] spd_tab [4];
    logic [3:0] div_tab [4];
    int errors = 0;
    int n_tests = 0;
    int cyc = 0;

    always #10 sys_clk_i = ~sys_clk_i;

    codec_port codec_port_inst (
        .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
        .hready_i(hreadyout), .hreadyout_o(hreadyout), .hresp_o(), .hrdata_o(hrdata),
        .power_up_reset_n_i(pur_n), .law_sel_a_i(law), .receive_quiet_force_i(rxq),
        .transmit_quiet_force_i(txq), .clock_speed_sel_bit0_i(spd[0]),
        .clock_speed_sel_bit1_i(spd[1]), .clock_speed_sel_bit2_i(spd[2]),
        .core_clock_in_i(core_clk), .serial_bit_clock_i(bclk), .slot_strobe_i(strobe),
        .serial_data_i(din), .serial_data_o(dout), .serial_data_oe_o(oe)
    );
    // shortened frame keeps the run short; nothing inside depends on it
    ssi_far_end #(.FRAME_NS(20000)) ssi_far_end_inst (
        .slow_i(slow), .dout_i(dout), .oe_i(oe), .bclk_o(bclk), .strobe_o(strobe),
        .din_o(din), .core_clk_o(core_clk)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, a};
        tick(1);
        while (hreadyout !== 1'b1) tick(1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        tick(1);
        while (hreadyout !== 1'b1) tick(1);
        v = hrdata;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e)
        begin
            errors++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        ahb(1'b0, a, 32'h0);
        chk(v, e);
    endtask
    task automatic run(input logic [7:0] s);
        ssi_far_end_inst.frame(s, got);
        tick(9);
    endtask
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    always @(posedge sys_clk_i)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            errors++;
            $display("[ERR] %0t run hung", $time);
            give_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        spd_tab = '{codec_port_pkg::SPD_512, codec_port_pkg::SPD_1536, codec_port_pkg::SPD_2048,
            codec_port_pkg::SPD_4096};
        div_tab = '{codec_port_pkg::DIV_1, codec_port_pkg::DIV_3, codec_port_pkg::DIV_4,
            codec_port_pkg::DIV_8};
        tick(6);
        nrst_i <= 1'b1;
        tick(8);
        rdc(codec_port_pkg::CTRL_OFS, 32'h0);
        rdc(codec_port_pkg::FRAMES_OFS, 32'h0);
        ahb(1'b1, 8'h40, 32'hffffffff);
        rdc(8'h40, 32'h0);
        for (int k = 0; k < 6; k++)
        begin
            {txq, rxq, law} <= k[2:0];
            spd <= k[2:0];
            tick(8);
            ahb(1'b0, codec_port_pkg::STATUS_OFS, 32'h0);
            chk(v & 32'h77, {25'h0, k[2:0], 1'b0, k[2:0]});
        end
        $display("test registers done");
        ahb(1'b1, codec_port_pkg::CTRL_OFS, 32'h1);
        for (int l = 0; l < 2; l++)
        begin
            law <= l[0];
            {txq, rxq} <= 2'h3;
            spd <= codec_port_pkg::SPD_4096;
            q = l ? codec_port_pkg::QUIET_A : codec_port_pkg::QUIET_MU;
            tick(8);
            ahb(1'b1, codec_port_pkg::TXDATA_OFS, 32'h80);
            run(8'hd5);
            chk({24'h0, got}, {24'h0, q});
            ahb(1'b0, codec_port_pkg::RXDATA_OFS, 32'h0);
            chk(v & 32'h1ff, {23'h1, q});
            {txq, rxq} <= 2'h0;
            tick(8);
            ahb(1'b1, codec_port_pkg::TXDATA_OFS, l ? 32'haa : 32'h80);
            run(l ? 8'h2a : 8'h00);
            chk({24'h0, got}, l ? 32'haa : 32'h80);
            ahb(1'b0, codec_port_pkg::RXDATA_OFS, 32'h0);
            chk(v & 32'h1ff, l ? 32'h12a : 32'h100);
        end
        $display("test law and quiet done");
        ahb(1'b1, codec_port_pkg::TXDATA_OFS, 32'h11);
        ahb(1'b1, codec_port_pkg::TXDATA_OFS, 32'h22);
        ahb(1'b0, codec_port_pkg::STATUS_OFS, 32'h0);
        chk(v & 32'h300, 32'h100);
        // third write stalls until the slot pops the oldest byte
        fork
            ahb(1'b1, codec_port_pkg::TXDATA_OFS, 32'h33);
            run(8'h61);
        join
        chk({24'h0, got}, 32'h11);
        run(8'h62);
        chk({24'h0, got}, 32'h22);
        run(8'h63);
        chk({24'h0, got}, 32'h33);
        run(8'h64);
        chk({24'h0, got}, 32'h55);
        ahb(1'b0, codec_port_pkg::RXDATA_OFS, 32'h0);
        chk(v & 32'h3ff, 32'h364);
        ahb(1'b0, codec_port_pkg::RXDATA_OFS, 32'h0);
        chk(v & 32'h300, 32'h0);
        rdc(codec_port_pkg::FRAMES_OFS, 32'h8);
        ahb(1'b1, codec_port_pkg::CTRL_OFS, 32'h0);
        run(8'h65);
        chk({24'h0, got}, 32'hff);
        $display("test buffer done");
        ahb(1'b1, codec_port_pkg::CTRL_OFS, 32'h1);
        pur_n <= 1'b0;
        tick(10);
        pur_n <= 1'b1;
        tick(8);
        rdc(codec_port_pkg::CTRL_OFS, 32'h0);
        rdc(codec_port_pkg::FRAMES_OFS, 32'h0);
        rdc(codec_port_pkg::TICKS_OFS, 32'h0);
        ahb(1'b1, codec_port_pkg::CTRL_OFS, 32'h1);
        for (int k = 0; k < 4; k++)
        begin
            spd <= spd_tab[k];
            tick(8);
            ahb(1'b0, codec_port_pkg::TICKS_OFS, 32'h0);
            t0 = v;
            run(8'h00);
            rdc(codec_port_pkg::TICKS_OFS, t0 + 32'd8 / div_tab[k]);
        end
        $display("test power-up and speed done");
        spd <= codec_port_pkg::SPD_128;
        slow <= 1'b1;
        tick(8);
        ahb(1'b1, codec_port_pkg::TXDATA_OFS, 32'h5a);
        run(8'hc3);
        ahb(1'b1, codec_port_pkg::TXDATA_OFS, 32'h3c);
        run(8'h96);
        chk({24'h0, got}, 32'h5a);
        ahb(1'b0, codec_port_pkg::RXDATA_OFS, 32'h0);
        chk(v & 32'hff, 32'hc3);
        $display("test slow clock done");
        give_verdict();
    end
endmodule // tb_codec_port
